/* File: logic/tao_alarm.sv */
// Function
// - both alarm outputs are active low after reset.
// - config bit 2 set makes critical alarm active high.
// - config bit 3 set makes general alarm active high.
// - general alarm has comparator and interrupt behaviour, comparator after reset.
// - alarm asserts when temperature above upper or below lower limit.
// - comparator alarm releases below upper minus hysteresis or above lower plus.
// - comparator mode: shutdown leaves the alarm state unchanged.
// - interrupt mode: any register read clears the latched alarm.
// - interrupt mode: reassert only on a fresh out-of-limit comparison.
// - interrupt mode: entering shutdown clears the alarm.
// - hysteresis is four bits unsigned degrees, reset five.
// - upper limit is 16-bit two's complement, reset 64 degrees.
// - lower limit is 16-bit two's complement, reset 10 degrees.
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module tao_alarm (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        ce,
  // register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  // conversion results
  input  wire logic        conv_done,
  input  wire logic [15:0] temp_value,
  // critical level from the critical comparator, active high
  input  wire logic        critical_raw,
  // open-drain pins
  output logic             alarm_out,
  output logic             alarm_oe,
  output logic             critical_alarm_out,
  output logic             critical_alarm_oe
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  tao_pkg::tao_bus_t bus;
  logic [7:0]  config_q;
  logic [3:0]  hysteresis_value_q;
  logic [15:0] upper_limit_q;
  logic [15:0] lower_limit_q;
  logic [15:0] reg_rdata_q;
  logic        alarm_q;
  logic        alarm_is_low_q;
  logic        shdn_prev_q;
  logic        over;
  logic        under;
  logic        below_rel;
  logic        above_rel;
  logic        int_mode;
  logic        shdn;
  logic        shdn_enter;
  logic        eval;

  assign bus = '{rd: reg_rd, wr: reg_wr, addr: reg_addr, wdata: reg_wdata};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_q <= tao_pkg::CONFIG_RST;
    end else if (ce && bus.wr && bus.addr == tao_pkg::ADDR_CONFIG) begin
      config_q <= bus.wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hysteresis_value_q <= tao_pkg::HYST_RST;
    end else if (ce && bus.wr && bus.addr == tao_pkg::ADDR_HYST) begin
      hysteresis_value_q <= bus.wdata[3:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      upper_limit_q <= tao_pkg::UPPER_RST;
    end else if (ce && bus.wr && bus.addr == tao_pkg::ADDR_UPPER) begin
      upper_limit_q <= bus.wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lower_limit_q <= tao_pkg::LOWER_RST;
    end else if (ce && bus.wr && bus.addr == tao_pkg::ADDR_LOWER) begin
      lower_limit_q <= bus.wdata;
    end
  end

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // unmapped indices read zero; data valid only the cycle after rd
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 16'h0000;
    end else if (ce) begin
      if (bus.rd) begin
        case (bus.addr)
          tao_pkg::ADDR_CONFIG: reg_rdata_q <= {8'h00, config_q};
          tao_pkg::ADDR_HYST:   reg_rdata_q <= {12'h000, hysteresis_value_q};
          tao_pkg::ADDR_UPPER:  reg_rdata_q <= upper_limit_q;
          tao_pkg::ADDR_LOWER:  reg_rdata_q <= lower_limit_q;
          default:              reg_rdata_q <= 16'h0000;
        endcase
      end else begin
        reg_rdata_q <= 16'h0000;
      end
    end
  end
  assign reg_rdata = reg_rdata_q;

  // ---------------------------------------------------------------
  // limit comparison
  // ---------------------------------------------------------------
  tao_limit_cmp u_cmp (
    .temp      (temp_value),
    .upper     (upper_limit_q),
    .lower     (lower_limit_q),
    .hyst      (hysteresis_value_q),
    .over      (over),
    .under     (under),
    .below_rel (below_rel),
    .above_rel (above_rel)
  );

  assign int_mode   = config_q[tao_pkg::CFG_MODE_BIT];
  assign shdn       = config_q[tao_pkg::CFG_SHDN_BIT];
  assign shdn_enter = shdn && !shdn_prev_q;
  // no conversions run while shut down
  assign eval       = conv_done && !shdn;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shdn_prev_q <= 1'b0;
    end else if (ce) begin
      shdn_prev_q <= shdn;
    end
  end

  // ---------------------------------------------------------------
  // alarm state
  // ---------------------------------------------------------------
  // alarm_is_low_q remembers which limit tripped the comparator alarm
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_q        <= 1'b0;
      alarm_is_low_q <= 1'b0;
    end else if (ce) begin
      if (!int_mode) begin
        // shutdown stops evaluation but leaves the level alone
        if (eval) begin
          if (over || under) begin
            alarm_q        <= 1'b1;
            alarm_is_low_q <= under;
          end else if (alarm_q && !alarm_is_low_q && below_rel) begin
            alarm_q <= 1'b0;
          end else if (alarm_q && alarm_is_low_q && above_rel) begin
            alarm_q <= 1'b0;
          end
        end
      end else begin
        // a fresh event in the read cycle wins over the clear
        if (eval && (over || under)) begin
          alarm_q <= 1'b1;
        end else if (bus.rd || shdn_enter) begin
          alarm_q <= 1'b0;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // pin polarity
  // ---------------------------------------------------------------
  // open drain: pin pulled low when oe is high, level is then 0
  assign alarm_out          = 1'b0;
  assign critical_alarm_out = 1'b0;
  assign alarm_oe           = config_q[tao_pkg::CFG_INT_POL_BIT] ? !alarm_q
                                                                 : alarm_q;
  assign critical_alarm_oe  = config_q[tao_pkg::CFG_CRIT_POL_BIT] ? !critical_raw
                                                                  : critical_raw;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_fresh_event;
    ce && eval && (over || under);
  endsequence

  sequence s_cfg_write;
    ce && bus.wr && bus.addr == tao_pkg::ADDR_CONFIG;
  endsequence

  sequence s_reg_read;
    ce && bus.rd;
  endsequence

  // a release needs a conversion that is neither a fresh event nor inside the band
  sequence s_high_release;
    ce && !int_mode && eval && alarm_q && !alarm_is_low_q && !over && !under && below_rel;
  endsequence

  sequence s_low_release;
    ce && !int_mode && eval && alarm_q && alarm_is_low_q && !over && !under && above_rel;
  endsequence

  a_alarm_sets_event: assert property (@(posedge clk) disable iff (rst)
    s_fresh_event |=> alarm_q)
    else $error("alarm not set after limit event");

  a_int_read_clear: assert property (@(posedge clk) disable iff (rst)
    ce && int_mode && bus.rd && !(eval && (over || under)) |=> !alarm_q)
    else $error("read did not clear interrupt alarm");

  a_int_shdn_clear: assert property (@(posedge clk) disable iff (rst)
    ce && int_mode && shdn_enter && !(eval && (over || under)) |=> !alarm_q)
    else $error("shutdown did not clear interrupt alarm");

  a_cmp_shdn_hold: assert property (@(posedge clk) disable iff (rst)
    ce && !int_mode && $past(int_mode) == 1'b0 && shdn && $past(shdn) |=> $stable(alarm_q))
    else $error("comparator alarm moved during shutdown");

  a_int_no_spont: assert property (@(posedge clk) disable iff (rst)
    ce && int_mode && !alarm_q && !(eval && (over || under)) |=> !alarm_q)
    else $error("interrupt alarm set without fresh event");

  a_cmp_hyst_hold: assert property (@(posedge clk) disable iff (rst)
    ce && !int_mode && alarm_q && !alarm_is_low_q && !below_rel |=> alarm_q)
    else $error("comparator alarm released inside hysteresis band");

  a_no_eval_hold: assert property (@(posedge clk) disable iff (rst)
    ce && !int_mode && !conv_done |=> $stable(alarm_q))
    else $error("comparator alarm changed between conversions");

  a_alarm_pin_pol: assert property (@(posedge clk) disable iff (rst)
    alarm_oe == (alarm_q ^ config_q[tao_pkg::CFG_INT_POL_BIT]))
    else $error("alarm pin polarity wrong");

  a_crit_pin_pol: assert property (@(posedge clk) disable iff (rst)
    critical_alarm_oe == (critical_raw ^ config_q[tao_pkg::CFG_CRIT_POL_BIT]))
    else $error("critical pin polarity wrong");

  a_rdata_one_cycle: assert property (@(posedge clk) disable iff (rst)
    ce && bus.rd && bus.addr == tao_pkg::ADDR_UPPER |=> reg_rdata == $past(upper_limit_q))
    else $error("upper limit readback wrong");

  a_cmp_high_release: assert property (@(posedge clk) disable iff (rst)
    s_high_release |=> !alarm_q)
    else $error("comparator alarm not released below upper band");

  a_cmp_low_release: assert property (@(posedge clk) disable iff (rst)
    s_low_release |=> !alarm_q)
    else $error("comparator alarm not released above lower band");

  a_cmp_low_hold: assert property (@(posedge clk) disable iff (rst)
    ce && !int_mode && alarm_q && alarm_is_low_q && !above_rel |=> alarm_q)
    else $error("low alarm released inside hysteresis band");

  a_int_latch_hold: assert property (@(posedge clk) disable iff (rst)
    ce && int_mode && alarm_q && !bus.rd && !shdn_enter |=> alarm_q)
    else $error("interrupt alarm dropped without read");

  a_int_shdn_stays: assert property (@(posedge clk) disable iff (rst)
    ce && int_mode && shdn && !alarm_q |=> !alarm_q)
    else $error("interrupt alarm set during shutdown");

  a_cfg_write_lands: assert property (@(posedge clk) disable iff (rst)
    s_cfg_write |=> config_q == $past(bus.wdata[7:0]))
    else $error("config write lost");

  a_hyst_write_lands: assert property (@(posedge clk) disable iff (rst)
    ce && bus.wr && bus.addr == tao_pkg::ADDR_HYST |=> hysteresis_value_q == $past(bus.wdata[3:0]))
    else $error("hysteresis write lost");

  a_upper_write_lands: assert property (@(posedge clk) disable iff (rst)
    ce && bus.wr && bus.addr == tao_pkg::ADDR_UPPER |=> upper_limit_q == $past(bus.wdata))
    else $error("upper limit write lost");

  a_lower_write_lands: assert property (@(posedge clk) disable iff (rst)
    ce && bus.wr && bus.addr == tao_pkg::ADDR_LOWER |=> lower_limit_q == $past(bus.wdata))
    else $error("lower limit write lost");

  a_rdata_cfg_read: assert property (@(posedge clk) disable iff (rst)
    s_reg_read ##0 (bus.addr == tao_pkg::ADDR_CONFIG) |=> reg_rdata == {8'h00, $past(config_q)})
    else $error("config readback wrong");

  a_rdata_hyst_read: assert property (@(posedge clk) disable iff (rst)
    s_reg_read ##0 (bus.addr == tao_pkg::ADDR_HYST)
      |=> reg_rdata == {12'h000, $past(hysteresis_value_q)})
    else $error("hysteresis readback wrong");

  a_rdata_lower_read: assert property (@(posedge clk) disable iff (rst)
    s_reg_read ##0 (bus.addr == tao_pkg::ADDR_LOWER) |=> reg_rdata == $past(lower_limit_q))
    else $error("lower limit readback wrong");

  a_ce_freeze_state: assert property (@(posedge clk) disable iff (rst)
    !ce |=> $stable(alarm_q) && $stable(config_q) && $stable(reg_rdata_q))
    else $error("state moved while clock enable low");

endmodule

/* File: logic/tao_pkg.sv */
package tao_pkg;

  // ---------------------------------------------------------------
  // register map (index of each register on the plain port)
  // ---------------------------------------------------------------
  localparam logic [2:0] ADDR_CONFIG = 3'h1;
  localparam logic [2:0] ADDR_HYST   = 3'h5;
  localparam logic [2:0] ADDR_UPPER  = 3'h6;
  localparam logic [2:0] ADDR_LOWER  = 3'h7;

  // ---------------------------------------------------------------
  // configuration fields
  // ---------------------------------------------------------------
  localparam int CFG_CRIT_POL_BIT = 2;
  localparam int CFG_INT_POL_BIT  = 3;
  localparam int CFG_MODE_BIT     = 4;
  localparam int CFG_SHDN_BIT     = 5;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  CONFIG_RST = 8'h00;
  localparam logic [3:0]  HYST_RST   = 4'h5;
  localparam logic [15:0] UPPER_RST  = 16'h2000;
  localparam logic [15:0] LOWER_RST  = 16'h0500;

  // hysteresis is whole degrees; one degree is 0x0080 in the result word
  localparam int HYST_SHIFT = 7;

  typedef enum logic {TAO_CMP, TAO_INT} tao_mode_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } tao_bus_t;

endpackage

/* File: logic/tao_limit_cmp.sv */
`timescale 1ns/1ps
module tao_limit_cmp (
  // operands
  input  wire logic signed [15:0] temp,
  input  wire logic signed [15:0] upper,
  input  wire logic signed [15:0] lower,
  input  wire logic        [3:0]  hyst,
  // results
  output logic                    over,
  output logic                    under,
  output logic                    below_rel,
  output logic                    above_rel
);
  logic signed [17:0] hyst_w;
  logic signed [17:0] t_w;

  // widened to 18 bits so limit +/- hysteresis cannot wrap
  assign hyst_w    = signed'(18'(hyst)) <<< tao_pkg::HYST_SHIFT;
  assign t_w       = 18'(temp);
  assign over      = temp > upper;
  assign under     = temp < lower;
  assign below_rel = t_w < (18'(upper) - hyst_w);
  assign above_rel = t_w > (18'(lower) + hyst_w);
endmodule

/* File: verif/tao_host_model.sv */
`timescale 1ns/1ps
module tao_host_model (
  // pins as driven by the sensor
  input  wire logic alarm_out,
  input  wire logic alarm_oe,
  input  wire logic critical_alarm_out,
  input  wire logic critical_alarm_oe,
  // levels the host sees
  output logic      alarm_pin,
  output logic      crit_pin
);
  // ---------------------------------------------------------------
  // open-drain wires with board pull-ups
  // ---------------------------------------------------------------
  // a released pin floats up, never holds the last driven value
  assign alarm_pin = alarm_oe ? alarm_out : 1'b1;
  assign crit_pin  = critical_alarm_oe ? critical_alarm_out : 1'b1;
endmodule

/* File: verif/temp_alarm_output_logic_test.sv */
`timescale 1ns/1ps
module temp_alarm_output_logic_test;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic        conv_done = 1'b0;
  logic [15:0] temp_value = 16'h0000;
  logic        critical_raw = 1'b0;
  logic        alarm_out, alarm_oe, critical_alarm_out, critical_alarm_oe;
  logic        alarm_pin, crit_pin;
  int          n_fail = 0;
  int          n_checks = 0;
  logic [15:0] d;

  always #4 clk = ~clk;

  tao_alarm i_tao_alarm (.clk(clk), .rst(rst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done(conv_done),
    .temp_value(temp_value), .critical_raw(critical_raw), .alarm_out(alarm_out),
    .alarm_oe(alarm_oe), .critical_alarm_out(critical_alarm_out),
    .critical_alarm_oe(critical_alarm_oe));

  tao_host_model i_tao_host_model (.alarm_out(alarm_out), .alarm_oe(alarm_oe),
    .critical_alarm_out(critical_alarm_out), .critical_alarm_oe(critical_alarm_oe),
    .alarm_pin(alarm_pin), .crit_pin(crit_pin));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic pin(input logic ea, input logic ec);
    chk({14'h0000, alarm_pin, crit_pin}, {14'h0000, ea, ec});
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic conv(input logic [15:0] t);
    @(posedge clk);
    conv_done  <= 1'b1;
    temp_value <= t;
    @(posedge clk);
    conv_done <= 1'b0;
    #1;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(tao_pkg::ADDR_HYST, d);   chk(d, 16'h0005);
    rd(tao_pkg::ADDR_UPPER, d);  chk(d, 16'h2000);
    rd(tao_pkg::ADDR_LOWER, d);  chk(d, 16'h0500);
    rd(tao_pkg::ADDR_CONFIG, d); chk(d, 16'h0000);
    rd(3'h0, d);                 chk(d, 16'h0000);
    wr(tao_pkg::ADDR_HYST, 16'hFFFF);
    rd(tao_pkg::ADDR_HYST, d);   chk(d, 16'h000F);
    wr(tao_pkg::ADDR_HYST, 16'h0005);
    pin(1'b1, 1'b1);
    @(posedge clk);
    critical_raw <= 1'b1;
    @(posedge clk);
    #1 pin(1'b1, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_polarity();
    wr(tao_pkg::ADDR_CONFIG, 16'h0004); pin(1'b1, 1'b1);
    wr(tao_pkg::ADDR_CONFIG, 16'h000C); pin(1'b0, 1'b1);
    @(posedge clk);
    critical_raw <= 1'b0;
    @(posedge clk);
    #1 pin(1'b0, 1'b0);
    wr(tao_pkg::ADDR_CONFIG, 16'h0000); pin(1'b1, 1'b1);
    $display("test polarity done");
  endtask

  task automatic t_comparator();
    conv(16'h2000); pin(1'b1, 1'b1);
    conv(16'h2001); pin(1'b0, 1'b1);
    conv(16'h1D80); pin(1'b0, 1'b1);
    rd(tao_pkg::ADDR_UPPER, d); pin(1'b0, 1'b1);
    wr(tao_pkg::ADDR_CONFIG, 16'h0020); pin(1'b0, 1'b1);
    conv(16'h1000); pin(1'b0, 1'b1);
    wr(tao_pkg::ADDR_CONFIG, 16'h0000);
    conv(16'h1D7F); pin(1'b1, 1'b1);
    conv(16'h0500); pin(1'b1, 1'b1);
    conv(16'hFF00); pin(1'b0, 1'b1);
    conv(16'h0780); pin(1'b0, 1'b1);
    conv(16'h0781); pin(1'b1, 1'b1);
    $display("test comparator done");
  endtask

  // nothing may move while the clock enable is low
  task automatic t_clock_enable();
    @(posedge clk);
    ce <= 1'b0;
    conv(16'h7FFF);             pin(1'b1, 1'b1);
    wr(tao_pkg::ADDR_UPPER, 16'h0100);
    @(posedge clk);
    ce <= 1'b1;
    rd(tao_pkg::ADDR_UPPER, d); chk(d, 16'h2000);
    conv(16'h7FFF);             pin(1'b0, 1'b1);
    conv(16'h1000);             pin(1'b1, 1'b1);
    $display("test clock enable done");
  endtask

  task automatic t_interrupt();
    wr(tao_pkg::ADDR_CONFIG, 16'h0010);
    conv(16'h04FF); pin(1'b0, 1'b1);
    conv(16'h1000); pin(1'b0, 1'b1);
    rd(3'h0, d);    pin(1'b1, 1'b1);
    conv(16'h1000); pin(1'b1, 1'b1);
    conv(16'h7FFF); pin(1'b0, 1'b1);
    wr(tao_pkg::ADDR_CONFIG, 16'h0030);
    // the clear follows the shutdown bit one cycle later
    @(posedge clk);
    #1 pin(1'b1, 1'b1);
    wr(tao_pkg::ADDR_CONFIG, 16'h0010);
    conv(16'h8000); pin(1'b0, 1'b1);
    $display("test interrupt done");
  endtask

  task automatic t_mid_reset();
    wr(tao_pkg::ADDR_UPPER, 16'h1000);
    wr(tao_pkg::ADDR_CONFIG, 16'h001C); pin(1'b1, 1'b0);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 pin(1'b1, 1'b1);
    rd(tao_pkg::ADDR_UPPER, d);  chk(d, 16'h2000);
    rd(tao_pkg::ADDR_CONFIG, d); chk(d, 16'h0000);
    conv(16'h2001);              pin(1'b0, 1'b1);
    conv(16'h1D7F);              pin(1'b1, 1'b1);
    $display("test mid reset done");
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_polarity();
    t_comparator();
    t_clock_enable();
    t_interrupt();
    t_mid_reset();
    finish_test();
  end

  // the tests need about a hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_fail++;
    finish_test();
  end
endmodule
